/* hw/smrc_run_config.sv */
// main configuration register: run control, mode, checksum, soft reset

// Operation
// RULE1: thermal warning drops 10/15 mA source inputs to 2 mA unless disabled.
// RULE2: interrupt scheme bit: 0 static, 1 dynamic low pin assertion.
// RULE3: writing run bit 1 starts wetting current and input polling.
// RULE4: clearing run bit halts operation and keeps the device idle.
// RULE5: host stops the device before changing any other setting.
// RULE6: while running, run, checksum, reset bits and capture register accept writes.
// RULE7: poll bit 0 gives continuous wetting, 1 gives periodic polling.
// RULE8: writing checksum bit 1 computes checksum of all configuration bits.
// RULE9: host leaves configuration unchanged until the checksum finishes.
// RULE10: checksum completion sets its flag and pulls interrupt pin low.
// RULE11: checksum trigger bit clears itself once the computation ends.
// RULE12: window code maps to 64..2048 us, codes above Ch give 512 us.
// RULE13: period code maps to 2..4096 ms, codes above Ch give 8 ms.
// RULE14: writing 1 to bit 0 resets the whole device; 0 does nothing.
// RULE15: all fields clear at power-on and after software reset.
module smrc_run_config #(
  parameter int CYC_PER_US = smrc_pkg::CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [5:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic thermal_warning_i,
  input wire logic [9:0] current_source_mode_i,
  input wire logic [9:0] high_current_i,
  output logic [23:0] rdata_o,
  output logic running_o,
  output logic poll_mode_o,
  output logic wetting_on_o,
  output logic [9:0] reduce_to_2ma_o,
  output logic int_n_o,
  output logic sw_reset_o
);

  // ********************************
  // state
  // ********************************
  smrc_pkg::smrc_state_s s_q, s_d;
  logic window;
  logic cfg_wr;
  logic crc_start;
  logic swrst_req;
  logic fb;

  assign cfg_wr = wr_i && (addr_i == smrc_pkg::ADDR_CFG);
  assign swrst_req = cfg_wr && wdata_i[smrc_pkg::BIT_SWRST];
  assign crc_start = cfg_wr && !swrst_req && wdata_i[smrc_pkg::BIT_CRC]
    && (s_q.cst == smrc_pkg::SMRC_IDLE);

  smrc_poll_timer #(
    .CYC_PER_US(CYC_PER_US)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(running_o && poll_mode_o),
    .win_code_i(s_q.cfg[smrc_pkg::WIN_LSB +: 4]), // RULE12
    .per_code_i(s_q.cfg[smrc_pkg::PER_LSB +: 4]), // RULE13
    .window_o(window)
  );

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    s_d = s_q;
    fb = 1'b0;
    s_d.swrst = 1'b0;
    // pin is foreign to this clock
    s_d.tw_sync = {s_q.tw_sync[0], thermal_warning_i};

    if (cfg_wr)
    begin
      if (s_q.cfg[smrc_pkg::BIT_RUN])
      begin
        // settings stay frozen while running
        s_d.cfg[smrc_pkg::BIT_RUN] = wdata_i[smrc_pkg::BIT_RUN]; // RULE6
      end
      else
      begin
        s_d.cfg = wdata_i; // RULE3 RULE4
      end
      // these bits are status, never stored from the bus
      s_d.cfg[smrc_pkg::BIT_CRC] = s_q.cfg[smrc_pkg::BIT_CRC];
      s_d.cfg[smrc_pkg::BIT_SWRST] = 1'b0;
    end
    if (wr_i && addr_i == smrc_pkg::ADDR_CAP)
    begin
      s_d.cap = wdata_i; // RULE6
    end

    // checksum engine, one bit per clock from a snapshot
    case (s_q.cst)
      smrc_pkg::SMRC_IDLE:
      begin
        if (crc_start)
        begin
          s_d.cst = smrc_pkg::SMRC_CALC; // RULE8
          s_d.cfg[smrc_pkg::BIT_CRC] = 1'b1;
          s_d.shreg = {s_q.cfg, s_q.cap};
          s_d.crc = smrc_pkg::CRC_INIT;
          s_d.bitcnt = '0;
        end
      end
      smrc_pkg::SMRC_CALC:
      begin
        fb = s_q.crc[15] ^ s_q.shreg[47];
        s_d.crc = {s_q.crc[14:0], 1'b0} ^ (fb ? smrc_pkg::CRC_POLY : 16'h0);
        s_d.shreg = {s_q.shreg[46:0], 1'b0};
        s_d.bitcnt = s_q.bitcnt + 6'd1;
        if (s_q.bitcnt == 6'(smrc_pkg::CRC_BITS - 1))
        begin
          s_d.cst = smrc_pkg::SMRC_IDLE;
          s_d.cfg[smrc_pkg::BIT_CRC] = 1'b0; // RULE11
          s_d.flag = 1'b1; // RULE10
          s_d.pulse = smrc_pkg::INT_PULSE_CYC;
        end
      end
      default:
      begin
        s_d.cst = smrc_pkg::SMRC_IDLE;
      end
    endcase

    // status read clears the flag only while the engine is idle, a new completion wins
    if (rd_i && addr_i == smrc_pkg::ADDR_STAT && !s_d.flag)
    begin
      s_d.flag = 1'b0;
    end
    else if (rd_i && addr_i == smrc_pkg::ADDR_STAT && s_q.cst ==
      smrc_pkg::SMRC_IDLE)
    begin
      s_d.flag = 1'b0;
    end
    if (s_q.pulse != 8'h00 && s_d.pulse == s_q.pulse)
    begin
      s_d.pulse = s_q.pulse - 8'h01;
    end

    // sink-mode inputs are left alone, only sources reduce
    if (s_q.tw_sync[1] && !s_q.cfg[smrc_pkg::BIT_TWOFF]
      && s_q.cfg[smrc_pkg::BIT_RUN])
    begin
      s_d.reduce = current_source_mode_i & high_current_i; // RULE1
    end
    else
    begin
      s_d.reduce = '0;
    end

    if (rd_i)
    begin
      case (addr_i)
        smrc_pkg::ADDR_CFG: s_d.rdata = s_q.cfg;
        smrc_pkg::ADDR_CAP: s_d.rdata = s_q.cap;
        smrc_pkg::ADDR_CRC: s_d.rdata = {8'h00, s_q.crc};
        smrc_pkg::ADDR_STAT: s_d.rdata = {23'h0, s_q.flag};
        default: s_d.rdata = '0;
      endcase
    end

    if (swrst_req)
    begin
      s_d = '0; // RULE14 RULE15
      s_d.swrst = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0; // RULE15
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign rdata_o = s_q.rdata;
  assign running_o = s_q.cfg[smrc_pkg::BIT_RUN];
  assign poll_mode_o = s_q.cfg[smrc_pkg::BIT_POLL];
  // RULE7
  assign wetting_on_o = running_o && (!poll_mode_o || window);
  assign reduce_to_2ma_o = s_q.reduce;
  // RULE2 RULE10
  assign int_n_o = s_q.cfg[smrc_pkg::BIT_INTDYN] ? (s_q.pulse == 8'h00)
    : !s_q.flag;
  assign sw_reset_o = s_q.swrst;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_run_start: assert property (
    (cfg_wr && wdata_i[11] && !wdata_i[0]) |=> running_o // RULE3
  ) else $error("run bit write did not start operation");

  a_run_stop: assert property (
    (cfg_wr && !wdata_i[11] && !wdata_i[0]) |=> !running_o && !wetting_on_o // RULE4
  ) else $error("run bit clear did not halt operation");

  a_frozen_cfg: assert property (
    (running_o && cfg_wr && !wdata_i[0]) |=> s_q.cfg[8:1] == $past(s_q.cfg[8:1]) // RULE6
  ) else $error("locked field changed while running");

  a_continuous: assert property (
    (running_o && !poll_mode_o) |-> wetting_on_o // RULE7
  ) else $error("continuous mode without wetting current");

  // length is held by the bit counter, not by a long repetition
  a_crc_done: assert property (
    (s_q.cst == smrc_pkg::SMRC_CALC && s_q.bitcnt == 6'd47 && !swrst_req)
      |=> !s_q.cfg[9] && s_q.flag // RULE8
  ) else $error("checksum did not finish on its last bit");

  a_crc_count: assert property (
    (s_q.cst == smrc_pkg::SMRC_CALC) |-> s_q.bitcnt <= 6'd47 // RULE8
  ) else $error("checksum bit counter ran past 48 bits");

  a_crc_begin: assert property (
    crc_start |=> s_q.cst == smrc_pkg::SMRC_CALC && s_q.bitcnt == 6'd0 // RULE8
  ) else $error("checksum trigger did not start the engine");

  a_trig_ignored: assert property (
    (s_q.cst == smrc_pkg::SMRC_CALC && cfg_wr && !swrst_req
      && s_q.bitcnt != 6'd47) |=> s_q.cst == smrc_pkg::SMRC_CALC // RULE11
  ) else $error("retrigger disturbed a running checksum");

  a_flag_clear: assert property (
    (rd_i && addr_i == smrc_pkg::ADDR_STAT
      && s_q.cst == smrc_pkg::SMRC_IDLE && !swrst_req) |=> !s_q.flag // RULE10
  ) else $error("status read left the checksum flag set");

  a_idle_dry: assert property (
    !running_o |-> !wetting_on_o // RULE4
  ) else $error("wetting current on while stopped");

  a_swrst_pulse: assert property (
    swrst_req |=> sw_reset_o // RULE14
  ) else $error("software reset pulse missing");

  a_crc_selfclr: assert property (
    (s_q.cst == smrc_pkg::SMRC_CALC) |-> s_q.cfg[9] // RULE11
  ) else $error("checksum bit low while computing");

  a_int_static: assert property (
    (s_q.flag && !s_q.cfg[12]) |-> !int_n_o // RULE10
  ) else $error("static interrupt not held low");

  a_dyn_pulse: assert property (
    ($rose(s_q.flag) && s_q.cfg[12] && !swrst_req) |-> !int_n_o // RULE2
  ) else $error("dynamic interrupt pulse missing");

  a_swrst_clear: assert property (
    swrst_req |=> s_q.cfg == smrc_pkg::CFG_RESET && s_q.cap == 24'h0 // RULE14
  ) else $error("software reset left fields set");

  a_reduce: assert property (
    (s_q.tw_sync[1] && !s_q.cfg[13] && running_o && !swrst_req)
      |=> reduce_to_2ma_o == $past(current_source_mode_i & high_current_i) // RULE1
  ) else $error("thermal reduction not applied");

  c_run: cover property (cfg_wr && wdata_i[11] ##1 running_o);
  c_crc: cover property ($rose(s_q.flag));
  c_poll: cover property (running_o && poll_mode_o && window);
  c_swrst: cover property (sw_reset_o);
  c_dyn: cover property ($rose(s_q.flag) && s_q.cfg[12]);

endmodule

/* hw/smrc_pkg.sv */
// shared constants, types and code tables for the run-config register block
package smrc_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [5:0] ADDR_CFG = 6'h1a;
  localparam logic [5:0] ADDR_CAP = 6'h30;
  localparam logic [5:0] ADDR_CRC = 6'h31;
  localparam logic [5:0] ADDR_STAT = 6'h32;
  localparam logic [23:0] CFG_RESET = 24'h000000;

  // ********************************
  // field positions in main_configuration
  // ********************************
  localparam int BIT_SWRST = 0;
  localparam int PER_LSB = 1;
  localparam int WIN_LSB = 5;
  localparam int BIT_CRC = 9;
  localparam int BIT_POLL = 10;
  localparam int BIT_RUN = 11;
  localparam int BIT_INTDYN = 12;
  localparam int BIT_TWOFF = 13;
  // bits software may still change while running
  localparam logic [23:0] LIVE_MASK = 24'h000a01;

  // ********************************
  // checksum and interrupt timing
  // ********************************
  localparam int CRC_BITS = 48;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [7:0] INT_PULSE_CYC = 8'h08;
  localparam int CLK_MHZ = 125;
  localparam int CH_N = 10;

  typedef enum logic [0:0] {
    SMRC_IDLE = 1'b0,
    SMRC_CALC = 1'b1
  } smrc_crc_e;

  typedef struct packed {
    logic [23:0] cfg;
    logic [23:0] cap;
    logic [15:0] crc;
    logic flag;
    smrc_crc_e cst;
    logic [5:0] bitcnt;
    logic [47:0] shreg;
    logic [1:0] tw_sync;
    logic [9:0] reduce;
    logic [23:0] rdata;
    logic [7:0] pulse;
    logic swrst;
  } smrc_state_s;

  typedef struct packed {
    logic [6:0] pre;
    logic [21:0] us;
    logic win;
  } smrc_tmr_s;

  // active window in microseconds
  function automatic logic [21:0] win_us(input logic [3:0] code);
    case (code)
      4'h8: win_us = 22'd640;
      4'h9: win_us = 22'd768;
      4'ha: win_us = 22'd896;
      4'hb: win_us = 22'd1024;
      4'hc: win_us = 22'd2048;
      4'hd, 4'he, 4'hf: win_us = 22'd512;
      default: win_us = 22'((code + 22'd1) * 22'd64);
    endcase
  endfunction

  // poll period in microseconds
  function automatic logic [21:0] per_us(input logic [3:0] code);
    case (code)
      4'h0: per_us = 22'd2000;
      4'h1: per_us = 22'd4000;
      4'h2: per_us = 22'd8000;
      4'h3: per_us = 22'd16000;
      4'h4: per_us = 22'd32000;
      4'h5: per_us = 22'd48000;
      4'h6: per_us = 22'd64000;
      4'h7: per_us = 22'd128000;
      4'h8: per_us = 22'd256000;
      4'h9: per_us = 22'd512000;
      4'ha: per_us = 22'd1024000;
      4'hb: per_us = 22'd2048000;
      4'hc: per_us = 22'd4096000;
      default: per_us = 22'd8000;
    endcase
  endfunction

endpackage

/* hw/smrc_poll_timer.sv */
// periodic polling timer: opens the wetting window at each period start
module smrc_poll_timer #(
  parameter int CYC_PER_US = smrc_pkg::CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [3:0] win_code_i,
  input wire logic [3:0] per_code_i,
  output logic window_o
);

  smrc_pkg::smrc_tmr_s s_q, s_d;
  logic [21:0] win_len;
  logic [21:0] per_len;

  always_comb
  begin
    win_len = smrc_pkg::win_us(win_code_i);
    per_len = smrc_pkg::per_us(per_code_i);
    s_d = s_q;
    if (!run_i)
    begin
      s_d = '0;
      // count restarts at zero, so the first window opens on the run edge
      s_d.win = 1'b1;
    end
    else
    begin
      if (s_q.pre == 7'(CYC_PER_US - 1))
      begin
        s_d.pre = '0;
        // period end wraps to the next window
        if (s_q.us >= per_len - 22'd1)
        begin
          s_d.us = '0;
        end
        else
        begin
          s_d.us = s_q.us + 22'd1;
        end
      end
      else
      begin
        s_d.pre = s_q.pre + 7'd1;
      end
      s_d.win = (s_d.us < win_len);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign window_o = run_i && s_q.win;

endmodule

/* testbench/smrc_host_model.sv */
// host controller model that drives the register port
module smrc_host_model (
  input wire logic clk_i,
  input wire logic [23:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [5:0] addr_o,
  output logic [23:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 24'h000000;
  end

  // ********
  // bus cycles
  // ********
  // one-cycle strobe; released data is inverted so stale values never match
  task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask

  // stop first so a half-applied setting never reaches the inputs
  task automatic reconfig(input logic [23:0] d);
    wr_reg(smrc_pkg::ADDR_CFG, d & ~24'h000800);
    wr_reg(smrc_pkg::ADDR_CFG, d);
  endtask
endmodule

/* testbench/smrc_run_config_tb.sv */
// self-checking bench for the run-config register block
module smrc_run_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] A_CFG = smrc_pkg::ADDR_CFG;
  localparam logic [23:0] CAP_VAL = 24'h00a5c3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tw = 1'b0;
  logic [9:0] src = 10'h000;
  logic [9:0] hic = 10'h000;
  logic wr;
  logic rd;
  logic [5:0] addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic running;
  logic poll;
  logic wet;
  logic int_n;
  logic swr;
  logic [9:0] red;
  logic [23:0] got;
  int n_mismatch = 0;
  int comparisons = 0;

  always #4 clk_i = ~clk_i;

  smrc_run_config #(
    .CYC_PER_US(1)
  ) u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr),
    .rd_i(rd),
    .addr_i(addr),
    .wdata_i(wdata),
    .thermal_warning_i(tw),
    .current_source_mode_i(src),
    .high_current_i(hic),
    .rdata_o(rdata),
    .running_o(running),
    .poll_mode_o(poll),
    .wetting_on_o(wet),
    .reduce_to_2ma_o(red),
    .int_n_o(int_n),
    .sw_reset_o(swr)
  );

  smrc_host_model u_host (
    .clk_i(clk_i),
    .rdata_i(rdata),
    .wr_o(wr),
    .rd_o(rd),
    .addr_o(addr),
    .wdata_o(wdata)
  );

  // ********
  // checking
  // ********
  task automatic chk_word(input logic [23:0] exp, input logic [23:0] act);
    comparisons++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  // reference checksum: msb first over {config, capture}
  function automatic logic [15:0] crc_ref(input logic [47:0] m);
    logic [15:0] c;
    c = smrc_pkg::CRC_INIT;
    for (int i = 47; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? smrc_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic chk_bit(input logic exp, input logic act);
    chk_word({23'h000000, exp}, {23'h000000, act});
  endtask

  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    u_host.rd_reg(A_CFG, got);
    chk_word(24'h000000, got);
    chk_bit(1'b1, int_n);
    u_host.rd_reg(6'h3f, got);
    chk_word(24'h000000, got);
  endtask

  task automatic t_run();
    u_host.wr_reg(A_CFG, 24'h000800);
    chk_bit(1'b1, running);
    chk_bit(1'b1, wet);
    u_host.wr_reg(A_CFG, 24'h003c00);
    u_host.rd_reg(A_CFG, got);
    chk_word(24'h000800, got);
    u_host.wr_reg(smrc_pkg::ADDR_CAP, CAP_VAL);
    u_host.rd_reg(smrc_pkg::ADDR_CAP, got);
    chk_word(CAP_VAL, got);
    u_host.wr_reg(A_CFG, 24'h000000);
    chk_bit(1'b0, running);
    chk_bit(1'b0, wet);
  endtask

  // static scheme holds the pin low, so the count saturates at 20
  task automatic t_crc(input logic [23:0] mode);
    logic [23:0] n;
    n = 24'h000000;
    u_host.reconfig(mode);
    u_host.wr_reg(A_CFG, mode | 24'h000200);
    u_host.rd_reg(A_CFG, got);
    chk_word(mode | 24'h000200, got);
    for (int i = 0; i < 80 && int_n !== 1'b0; i++)
      @(negedge clk_i);
    if (int_n !== 1'b0)
    begin
      n_mismatch++;
      stop_test();
    end
    while (int_n === 1'b0 && n < 24'd20)
    begin
      n++;
      @(negedge clk_i);
    end
    chk_word(mode[12] ? 24'd8 : 24'd20, n);
    u_host.rd_reg(smrc_pkg::ADDR_STAT, got);
    chk_word(24'h000001, got);
    chk_bit(1'b1, int_n);
    u_host.rd_reg(smrc_pkg::ADDR_CRC, got);
    chk_word({8'h00, crc_ref({mode, CAP_VAL})}, got);
    u_host.rd_reg(A_CFG, got);
    chk_word(mode, got);
  endtask

  task automatic t_thermal();
    src = 10'h2a5;
    hic = 10'h0f0;
    u_host.reconfig(24'h000800);
    tw = 1'b1;
    repeat (4) @(negedge clk_i);
    chk_word(24'h0000a0, {14'h0000, red});
    tw = 1'b0;
    u_host.reconfig(24'h002800);
    tw = 1'b1;
    repeat (4) @(negedge clk_i);
    chk_word(24'h000000, {14'h0000, red});
    tw = 1'b0;
    u_host.wr_reg(A_CFG, 24'h000000);
  endtask

  task automatic t_poll();
    logic [3:0] wc [4] = '{4'h0, 4'h8, 4'hd, 4'hc};
    logic [3:0] pc [4] = '{4'h0, 4'h0, 4'hd, 4'hc};
    int span [4] = '{4000, 2000, 4000, 4000};
    logic [23:0] ex [4] = '{24'd128, 24'd640, 24'd512, 24'd2048};
    logic [23:0] n;
    for (int k = 0; k < 4; k++)
    begin
      n = 24'h000000;
      u_host.reconfig({12'h000, 2'b11, 1'b0, wc[k], pc[k], 1'b0});
      chk_bit(1'b1, poll);
      for (int i = 0; i < span[k]; i++)
      begin
        n = n + 24'(wet);
        @(negedge clk_i);
      end
      chk_word(ex[k], n);
    end
    u_host.wr_reg(A_CFG, 24'h000000);
  endtask

  task automatic t_swrst();
    u_host.wr_reg(A_CFG, 24'h001c00);
    chk_bit(1'b0, swr);
    u_host.wr_reg(A_CFG, 24'h001c01);
    chk_bit(1'b1, swr);
    u_host.rd_reg(A_CFG, got);
    chk_word(24'h000000, got);
  endtask

  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_run();
    t_crc(24'h000000);
    t_crc(24'h001000);
    t_thermal();
    t_poll();
    t_swrst();
    stop_test();
  end
endmodule
